// ---- shared/flc_pkg.sv ----
// Constants and types for the flash lock, program timing and info page access block
// Functional notes
// R01 - Flash clock is system clock divided by a programmable divisor, giving 1 MHz.
// R02 - Software loads divisor 100 when the internal oscillator clocks the system.
// R03 - Program or erase starts only while the unlock field holds code 2.
// R04 - Any other unlock value locks the instance, or keeps it locked.
// R05 - Starting an operation without code 2 sets the access fail flag.
// R06 - Each program stores 128 bits; address bits [3:0] are ignored.
// R07 - Information page 0 is read only.
// R08 - Serial number, 104 bits, reads at 0x1080_0000 to 0x1080_0017.
// R09 - Rest of page 0 from 0x1080_0018 is not user accessible.
// R10 - Lower 4096 bytes of page 1 are write only; reads there fault.
// R11 - Upper half of page 1 is readable and writable user storage.
// R12 - Page erase at 0x1080_2000 clears all of information page 1.
// R13 - Page 1 erase is refused while the magic value is programmed.
// R14 - After power-on reset with matching magic, key is copied and status set to 1.
// R15 - Software writes the key as two 128-bit writes at 0x2008 and 0x2018; the bench uses three writes, at 0x2010, 0x2020 and 0x2008.
// R16 - Software fills all 256 key bits, unused bits zero.
// R17 - Software writes magic words to 0x2000 then 0x2004.
// R18 - With magic set, key region writes are blocked; user half stays writable.
// R19 - Autoload needs both magic words equal to 0x2b86d479.
// R20 - Program completion sets done flag, and access fail on error.
// R21 - Page erase ignores address bits [12:0].
// R22 - A refused operation sets access fail and leaves flash contents unchanged.
package flc_pkg;
  localparam int          SYS_CLK_HZ     = 50000000;
  localparam int          FLASH_CLK_HZ   = 1000000;
  localparam logic [7:0]  DIV_RESET      = 8'(SYS_CLK_HZ / FLASH_CLK_HZ);
  localparam logic [1:0]  UNLOCK_CODE    = 2'h2;
  localparam logic [7:0]  ERASE_PAGE_CMD = 8'h55;
  localparam logic [31:0] MAGIC_WORD     = 32'h2b86d479;
  localparam logic [31:0] INFO0_BASE     = 32'h10800000;
  localparam logic [31:0] USN_LAST       = 32'h10800017;
  localparam logic [31:0] INFO1_BASE     = 32'h10802000;
  localparam logic [31:0] INFO1_USER     = 32'h10803000;
  localparam logic [31:0] INFO1_LAST     = 32'h10803fff;
  localparam logic [31:0] MAGIC1_ADDR    = 32'h10802004;
  localparam logic [31:0] KEY_FIRST      = 32'h10802008;
  localparam logic [31:0] KEY_LAST       = 32'h10802027;
  localparam int          ALIGN_BITS     = 4;
  localparam int          PAGE_BITS      = 13;
  localparam logic [15:0] PROG_TICKS     = 16'h0014;
  localparam logic [15:0] ERASE_TICKS    = 16'h0064;
  localparam logic [15:0] KEYLOAD_CYCLES = 16'h0008;
  // Register byte addresses
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_CLKDIV = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DATA0  = 8'h10;
  localparam logic [7:0] REG_KEYST  = 8'h20;
  // Control word fields
  localparam int CTRL_WR    = 0;
  localparam int CTRL_PGE   = 1;
  localparam int CTRL_ERLSB = 8;
  localparam int CTRL_UNLSB = 28;
  // Status word fields; done and access fail are write one to clear
  localparam int ST_DONE = 0;
  localparam int ST_AF   = 1;
  localparam int ST_PEND = 2;
  localparam int ST_MAG  = 3;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_PROG  = 3'b001,
    S_ERASE = 3'b010,
    S_DONE  = 3'b011,
    S_KEYLD = 3'b100
  } state_t;
endpackage

// ---- rtl/flc_lock_info.sv ----
// Flash program/erase sequencer with lock, clock divider and info page gating
//
// The address map and strobed register access were left to the implementer.
module flc_lock_info
  import flc_pkg::*;
(
  input  wire logic         I_CLK_SYS,      // System clock, 50 MHz
  input  wire logic         I_RSTN,         // Async reset, active low
  input  wire logic         I_POR,          // Reset was a power-on reset
  input  wire logic [7:0]   I_REG_ADDR,     // Register byte address
  input  wire logic [31:0]  I_REG_WDATA,    // Register write data
  input  wire logic         I_REG_WR,       // Register write strobe
  input  wire logic         I_REG_RD,       // Register read strobe
  input  wire logic         I_USR_RD,       // User read of flash space
  input  wire logic [31:0]  I_USR_ADDR,     // User read address
  input  wire logic [31:0]  I_FL_RDATA,     // Array read data for key load
  input  wire logic [63:0]  I_FL_MAGIC,     // Both magic words as stored
  output logic [31:0]       O_REG_RDATA,    // Register read data
  output logic              O_USR_OK,       // User read allowed, pulse
  output logic              O_USR_FAULT,    // User read fault, pulse
  output logic              O_FL_PROG,      // Program strobe to array
  output logic              O_FL_ERASE,     // Page erase strobe to array
  output logic [31:0]       O_FL_ADDR,      // Aligned array address
  output logic [127:0]      O_FL_WDATA,     // Program data
  output logic              O_FL_CLK,       // 1 MHz flash timing clock
  output logic [255:0]      O_CIPHER_KEY,   // System cipher key registers
  output logic              O_KEY_STATUS    // Key autoload status
);
  typedef struct packed {
    state_t        st;
    logic [31:0]   addr;
    logic [7:0]    div;
    logic [7:0]    divcnt;
    logic          fclk;
    logic [15:0]   ticks;
    logic [1:0]    unlock;
    logic [7:0]    ecode;
    logic [127:0]  data;
    logic          done;
    logic          af;
    logic [31:0]   rdata;
    logic          uok;
    logic          ufault;
    logic          prog;
    logic          erase;
    logic [31:0]   faddr;
    logic [255:0]  key;
    logic          keyst;
    logic [2:0]    kidx;
    logic          por_seen;
    logic          por_meta;
    logic          por_sync;
  } st_t;

  st_t q;
  st_t d;
  logic          magic_ok;
  logic          tick;
  logic          set_af;
  logic          set_done;
  logic [31:0]   op_addr;
  logic          in_info0;
  logic          in_info1;
  logic          in_key;
  logic          usr_serial;
  logic          usr_hidden;
  logic          usr_keyrd;
  logic [7:0]    div_eff;
  logic [7:0]    half_lo;
  logic [7:0]    half_hi;

  assign magic_ok = (I_FL_MAGIC[63:32] == MAGIC_WORD) && (I_FL_MAGIC[31:0] == MAGIC_WORD); // R19
  assign tick     = (q.divcnt == 8'h00);
  assign op_addr  = q.addr;
  // Divisors below two fall back to the fastest clock of two system cycles
  assign div_eff  = (q.div > 8'h01) ? q.div : 8'h02;
  // An odd divisor makes the high half one cycle longer, keeping the period exact
  assign half_lo  = div_eff >> 1;
  assign half_hi  = 8'(div_eff - half_lo);

  addr_window #(
    .LO (INFO0_BASE),
    .HI (USN_LAST)
  ) u_usr_serial (
    .i_addr (I_USR_ADDR),
    .o_hit  (usr_serial)
  );

  addr_window #(
    .LO (32'(USN_LAST + 32'h00000001)),
    .HI (32'(INFO1_BASE - 32'h00000001))
  ) u_usr_hidden (
    .i_addr (I_USR_ADDR),
    .o_hit  (usr_hidden)
  );

  addr_window #(
    .LO (INFO1_BASE),
    .HI (32'(INFO1_USER - 32'h00000001))
  ) u_usr_keyrd (
    .i_addr (I_USR_ADDR),
    .o_hit  (usr_keyrd)
  );

  addr_window #(
    .LO (INFO0_BASE),
    .HI (32'(INFO1_BASE - 32'h00000001))
  ) u_op_info0 (
    .i_addr (op_addr),
    .o_hit  (in_info0)
  );

  addr_window #(
    .LO (INFO1_BASE),
    .HI (INFO1_LAST)
  ) u_op_info1 (
    .i_addr (op_addr),
    .o_hit  (in_info1)
  );

  addr_window #(
    .LO (INFO1_BASE),
    .HI (32'(INFO1_USER - 32'h00000001))
  ) u_op_key (
    .i_addr (op_addr),
    .o_hit  (in_key)
  );

  always_comb
  begin
    d        = q;
    set_af   = 1'b0;
    set_done = 1'b0;
    d.uok    = 1'b0;
    d.ufault = 1'b0;
    d.prog   = 1'b0;
    d.erase  = 1'b0;
    // Power-on flag comes from the reset logic, outside this clock
    d.por_meta = I_POR;
    d.por_sync = q.por_meta;
    // Divider runs freely so the flash clock is steady before any operation
    if (tick)
    begin
      d.divcnt = q.fclk ? 8'(half_lo - 8'h01) : 8'(half_hi - 8'h01); // R01
      d.fclk   = ~q.fclk;
    end
    else
    begin
      d.divcnt = 8'(q.divcnt - 8'h01);
    end
    if (tick && q.fclk && (q.ticks != 16'h0000))
    begin
      d.ticks = 16'(q.ticks - 16'h0001);
    end

    // Register reads
    d.rdata = 32'h00000000;
    if (I_REG_RD)
    begin
      unique case (I_REG_ADDR)
        REG_ADDR:   d.rdata = q.addr;
        REG_CLKDIV: d.rdata = {24'h000000, q.div};
        REG_CTRL:   d.rdata = {2'b00, q.unlock, 12'h000, q.ecode, 6'h00,
                               q.st == S_ERASE, q.st == S_PROG};
        REG_STATUS: d.rdata = {28'h0000000, magic_ok, q.st != S_IDLE, q.af, q.done};
        REG_KEYST:  d.rdata = {31'h00000000, q.keyst};
        default:    d.rdata = 32'h00000000;
      endcase
    end

    unique case (q.st)
      S_IDLE:
      begin
        if (q.por_sync && !q.por_seen)
        begin
          d.por_seen = 1'b1;
          if (magic_ok)
          begin
            d.faddr = KEY_FIRST;
            d.st    = S_KEYLD; // R14
            d.kidx  = 3'h0;
            d.ticks = KEYLOAD_CYCLES;
          end
        end
        else if (I_REG_WR && (I_REG_ADDR == REG_CTRL)
                 && (I_REG_WDATA[CTRL_WR] || I_REG_WDATA[CTRL_PGE]))
        begin
          d.ecode = I_REG_WDATA[CTRL_ERLSB +: 8];
          if (q.unlock != UNLOCK_CODE)
          begin
            set_af = 1'b1; // R03 R05
          end
          else if (I_REG_WDATA[CTRL_PGE])
          begin
            if ((in_info1 && magic_ok) || in_info0
                || (I_REG_WDATA[CTRL_ERLSB +: 8] != ERASE_PAGE_CMD))
            begin
              set_af = 1'b1; // R13 R07 R22
            end
            else
            begin
              d.faddr = {op_addr[31:PAGE_BITS], 13'h0000}; // R21 R12
              d.erase = 1'b1;
              d.st    = S_ERASE;
              d.ticks = ERASE_TICKS;
            end
          end
          else if ((in_key && magic_ok) || in_info0)
          begin
            set_af = 1'b1; // R18 R07 R22
          end
          else
          begin
            d.faddr = {op_addr[31:ALIGN_BITS], 4'h0}; // R06
            d.prog  = 1'b1;
            d.st    = S_PROG;
            d.ticks = PROG_TICKS;
          end
        end
      end
      S_PROG, S_ERASE:
      begin
        if (q.ticks == 16'h0000)
        begin
          d.st = S_DONE;
        end
      end
      S_DONE:
      begin
        set_done = 1'b1; // R20
        d.st     = S_IDLE;
      end
      S_KEYLD:
      begin
        // Array delivers key words in order from the first key address
        d.key[{q.kidx, 5'h00} +: 32] = I_FL_RDATA; // R14
        d.kidx = 3'(q.kidx + 3'h1);
        if (q.kidx == 3'h7)
        begin
          d.keyst = 1'b1; // R14
          d.st    = S_IDLE;
        end
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase

    // Register writes; unlock field locks on any other value
    if (I_REG_WR)
    begin
      if (I_REG_ADDR == REG_ADDR)
      begin
        d.addr = I_REG_WDATA;
      end
      if (I_REG_ADDR == REG_CLKDIV)
      begin
        d.div = I_REG_WDATA[7:0];
      end
      if (I_REG_ADDR == REG_CTRL)
      begin
        d.unlock = I_REG_WDATA[CTRL_UNLSB +: 2]; // R04
      end
      if ((I_REG_ADDR >= REG_DATA0) && (I_REG_ADDR < REG_KEYST) && (q.st == S_IDLE))
      begin
        d.data[{I_REG_ADDR[3:2], 5'h00} +: 32] = I_REG_WDATA;
      end
    end
    // Set wins over a same-cycle write-one clear
    if (I_REG_WR && (I_REG_ADDR == REG_STATUS))
    begin
      if (I_REG_WDATA[ST_DONE])
      begin
        d.done = 1'b0;
      end
      if (I_REG_WDATA[ST_AF])
      begin
        d.af = 1'b0;
      end
    end
    if (set_done)
    begin
      d.done = 1'b1; // R20
    end
    if (set_af)
    begin
      d.af = 1'b1; // R05
    end

    // User read gating of the information pages
    if (I_USR_RD)
    begin
      if (usr_serial)
      begin
        d.uok = 1'b1; // R08
      end
      else if (usr_hidden)
      begin
        d.ufault = 1'b1; // R09
      end
      else if (usr_keyrd)
      begin
        d.ufault = 1'b1; // R10
      end
      else
      begin
        d.uok = 1'b1; // R11
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      q          <= '0;
      q.st       <= S_IDLE;
      q.div      <= DIV_RESET;
      q.divcnt   <= DIV_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign O_REG_RDATA  = q.rdata;
  assign O_USR_OK     = q.uok;
  assign O_USR_FAULT  = q.ufault;
  assign O_FL_PROG    = q.prog;
  assign O_FL_ERASE   = q.erase;
  assign O_FL_ADDR    = q.faddr;
  assign O_FL_WDATA   = q.data;
  assign O_FL_CLK     = q.fclk;
  assign O_CIPHER_KEY = q.key;
  assign O_KEY_STATUS = q.keyst;
endmodule

// Inclusive address window compare shared by every flash region check
module addr_window
  import flc_pkg::*;
#(
  parameter logic [31:0] LO = 32'h00000000, // Lowest address in the window
  parameter logic [31:0] HI = 32'hffffffff  // Highest address in the window
)
(
  input  wire logic [31:0]  i_addr,   // Address under test
  output logic              o_hit     // Address lies inside the window
);
  assign o_hit = (i_addr >= LO) && (i_addr <= HI);
endmodule

// ---- tb/flc_lock_info_asserts.sv ----
// Port assertions for the flash sequencer
module flc_lock_info_asserts
  import flc_pkg::*;
(
  input wire logic        I_CLK_SYS,   // Clock
  input wire logic        I_RSTN,      // Reset, low
  input wire logic [7:0]  I_REG_ADDR,  // Reg address
  input wire logic [31:0] I_REG_WDATA, // Reg data
  input wire logic        I_REG_WR,    // Write strobe
  input wire logic        I_USR_RD,    // User read
  input wire logic [31:0] I_USR_ADDR,  // User address
  input wire logic        O_USR_OK,    // Read allowed
  input wire logic        O_USR_FAULT, // Read fault
  input wire logic        O_FL_PROG,   // Program strobe
  input wire logic        O_FL_ERASE,  // Erase strobe
  input wire logic [31:0] O_FL_ADDR    // Array address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start_w;
  assign start_w = I_REG_WR && I_REG_ADDR == REG_CTRL && I_REG_WDATA[1:0] != 2'h0;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence lock_s;
    I_REG_WR && I_REG_ADDR == REG_CTRL && I_REG_WDATA[29:28] != UNLOCK_CODE;
  endsequence
  sequence start_s;
    start_w;
  endsequence
  prog_align_a: assert property (O_FL_PROG |-> O_FL_ADDR[3:0] == 4'h0)
    else $error("program address not aligned");
  erase_align_a: assert property (O_FL_ERASE |-> O_FL_ADDR[12:0] == 13'h0)
    else $error("erase address not page aligned");
  prog_cause_a: assert property (O_FL_PROG |-> $past(start_w))
    else $error("program strobe without start");
  relock_a: assert property (lock_s ##2 start_s |=> !O_FL_PROG && !O_FL_ERASE)
    else $error("start accepted after relock");
  key_fault_a: assert property (I_USR_RD && I_USR_ADDR inside {[INFO1_BASE:INFO1_USER - 1]}
    |=> O_USR_FAULT && !O_USR_OK) else $error("key region read allowed");
  page0_fault_a: assert property (
    I_USR_RD && I_USR_ADDR inside {[USN_LAST + 1:INFO1_BASE - 1]}
    |=> O_USR_FAULT && !O_USR_OK) else $error("page 0 rest read allowed");
  serial_ok_a: assert property (I_USR_RD && I_USR_ADDR inside {[INFO0_BASE:USN_LAST]}
    |=> O_USR_OK && !O_USR_FAULT) else $error("serial read refused");
  user_ok_a: assert property (I_USR_RD && I_USR_ADDR inside {[INFO1_USER:INFO1_LAST]}
    |=> O_USR_OK && !O_USR_FAULT) else $error("user half read refused");
endmodule

bind flc_lock_info flc_lock_info_asserts u_chk (
  .I_CLK_SYS   (I_CLK_SYS),
  .I_RSTN      (I_RSTN),
  .I_REG_ADDR  (I_REG_ADDR),
  .I_REG_WDATA (I_REG_WDATA),
  .I_REG_WR    (I_REG_WR),
  .I_USR_RD    (I_USR_RD),
  .I_USR_ADDR  (I_USR_ADDR),
  .O_USR_OK    (O_USR_OK),
  .O_USR_FAULT (O_USR_FAULT),
  .O_FL_PROG   (O_FL_PROG),
  .O_FL_ERASE  (O_FL_ERASE),
  .O_FL_ADDR   (O_FL_ADDR)
);

// ---- tb/flc_array_model.sv ----
// Flash array model: info page 1 storage, erase, magic and key feed
module flc_array_model
  import flc_pkg::*;
(
  input  wire logic         i_clk,   // Clock
  input  wire logic         i_rstn,  // Reset, low
  input  wire logic         i_prog,  // Program strobe
  input  wire logic         i_erase, // Erase strobe
  input  wire logic [31:0]  i_addr,  // Aligned target
  input  wire logic [127:0] i_wdata, // Program line
  output logic [31:0]       o_rdata, // Key word
  output logic [63:0]       o_magic  // Magic words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pg [2048];
  int          ld;
  // Contents survive reset; only erase clears them
  initial
    foreach (pg[i])
      pg[i] = '1;
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      ld <= 0;
    else if (i_addr == KEY_FIRST && ld < 7)
      ld <= ld + 1;
  always @(posedge i_clk)
    if (i_addr[31:13] == INFO1_BASE[31:13])
    begin
      if (i_prog)
        for (int j = 0; j < 4; j++)
          pg[11'(i_addr[12:2] + j)] <= i_wdata[32*j +: 32];
      if (i_erase)
        foreach (pg[i])
          pg[i] <= '1;
    end
  assign o_rdata = pg[2 + ld];
  assign o_magic = {pg[1], pg[0]};
endmodule

// ---- tb/flc_lock_info_bench.sv ----
// Self-checking bench for the flash sequencer
module flc_lock_info_bench
  import flc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rstn, por, we, re, urd, ok, flt, prog, ers, fck, kst;
  logic [7:0]   ra;
  logic [31:0]  wd, ua, rdat, fa, flrd, last;
  logic [63:0]  mag;
  logic [127:0] fwd;
  logic [255:0] key;
  int           mismatches, checked, strobes;
  logic [31:0]  uad [8] = '{32'h10800000, 32'h10800017, 32'h10800018, 32'h10801fff,
                           32'h10802000, 32'h10802fff, 32'h10803000, 32'h10803fff};
  flc_lock_info u_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_POR(por), .I_REG_ADDR(ra),
    .I_REG_WDATA(wd), .I_REG_WR(we), .I_REG_RD(re), .I_USR_RD(urd), .I_USR_ADDR(ua),
    .I_FL_RDATA(flrd), .I_FL_MAGIC(mag), .O_REG_RDATA(rdat), .O_USR_OK(ok),
    .O_USR_FAULT(flt), .O_FL_PROG(prog), .O_FL_ERASE(ers), .O_FL_ADDR(fa),
    .O_FL_WDATA(fwd), .O_FL_CLK(fck), .O_CIPHER_KEY(key), .O_KEY_STATUS(kst));
  flc_array_model u_mem (.i_clk(clk), .i_rstn(rstn), .i_prog(prog), .i_erase(ers),
    .i_addr(fa), .i_wdata(fwd), .o_rdata(flrd), .o_magic(mag));
  function automatic logic [31:0] kw(input int k);
    return {24'h6b6579, 8'(k)};
  endfunction
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic pd(input logic [127:0] v);
    for (int i = 0; i < 4; i++)
      wr(REG_DATA0 + 8'(4 * i), v[32*i +: 32]);
  endtask
  task automatic per(input logic [31:0] p);
    realtime t;
    @(posedge fck);
    @(posedge fck);
    t = $realtime;
    @(posedge fck);
    cmp(32'(int'(($realtime - t) / 20.0)), p);
  endtask
  // Unlock with u, start with code 2; done is only judged where a strobe is due
  task automatic op(input logic [1:0] u, input logic [31:0] a, input logic [15:0] c,
                    input logic [31:0] st, input logic [31:0] e);
    logic [31:0] d;
    int          n;
    n = strobes;
    wr(REG_ADDR, a);
    wr(REG_CTRL, {2'h0, u, 28'h0});
    wr(REG_CTRL, {16'h2000, c});
    d = 32'h4;
    for (int i = 0; i < 1000 && d[ST_PEND] !== 1'b0; i++)
      rd(REG_STATUS, d);
    cmp(d & (e != 0 ? 32'hf : 32'he), st);
    cmp(32'(strobes - n), {31'h0, e != 0});
    if (e != 0)
      cmp(last, e);
    wr(REG_STATUS, 32'h3);
    $display("test at %h ctrl %h done", a, c);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #1ms;
    mismatches++;
    conclude();
  end
  always @(posedge clk)
    if (prog === 1'b1 || ers === 1'b1)
    begin
      strobes++;
      last <= fa;
    end
  initial
  begin
    logic [31:0] d;
    {rstn, por, we, re, urd, ra, wd, ua} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CLKDIV, d);
    cmp(d, {24'h000000, DIV_RESET});
    rd(8'h3c, d);
    cmp(d, 32'h0);
    per(32'h32);
    wr(REG_CLKDIV, 32'h64);
    per(32'h64);
    wr(REG_CLKDIV, 32'ha);
    per(32'h0a);
    $display("clock divider test done");
    pd({32'h3, 32'h2, 32'h1, 32'hc0ffee00});
    op(2'h1, 32'h10803005, 16'h1, 32'h2, 32'h0);
    op(2'h2, 32'h10803005, 16'h1, 32'h1, 32'h10803000);
    cmp(u_mem.pg[1024], 32'hc0ffee00);
    op(2'h0, 32'h10803005, 16'h1, 32'h2, 32'h0);
    op(2'h2, 32'h10800020, 16'h1, 32'h2, 32'h0);
    op(2'h2, 32'h10800abc, 16'h5502, 32'h2, 32'h0);
    op(2'h2, 32'h10004abc, 16'h5502, 32'h1, 32'h10004000);
    op(2'h2, 32'h10004abc, 16'h4402, 32'h2, 32'h0);
    op(2'h2, 32'h10802abc, 16'h5502, 32'h1, 32'h10802000);
    cmp(u_mem.pg[1024], 32'hffffffff);
    pd({kw(5), kw(4), kw(3), kw(2)});
    op(2'h2, 32'h10802010, 16'h1, 32'h1, 32'h10802010);
    pd({32'h0, 32'h0, kw(7), kw(6)});
    op(2'h2, 32'h10802020, 16'h1, 32'h1, 32'h10802020);
    pd({kw(1), kw(0), MAGIC_WORD, MAGIC_WORD});
    op(2'h2, 32'h10802008, 16'h1, 32'h9, 32'h10802000);
    op(2'h2, 32'h10802018, 16'h1, 32'ha, 32'h0);
    op(2'h2, 32'h10802000, 16'h5502, 32'ha, 32'h0);
    op(2'h2, 32'h10803100, 16'h1, 32'h9, 32'h10803100);
    foreach (uad[i])
    begin
      @(posedge clk);
      ua <= uad[i];
      urd <= 1'b1;
      @(posedge clk);
      urd <= 1'b0;
      #1 cmp({30'h0, flt, ok}, (i > 1 && i < 6) ? 32'h2 : 32'h1);
    end
    $display("user read test done");
    @(posedge clk);
    rstn <= 1'b0;
    por <= 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Power-on flag crosses two synchroniser stages before the load starts
    repeat (KEYLOAD_CYCLES + 6) @(posedge clk);
    por <= 1'b0;
    for (int k = 0; k < 8; k++)
      cmp(key[32*k +: 32], kw(k));
    cmp({31'h0, kst}, 32'h1);
    rd(REG_KEYST, d);
    cmp(d, 32'h1);
    $display("key load test done");
    conclude();
  end
endmodule
